//--- pkg/adc_pwr_pkg.sv
// Purpose: shared constants and types for the converter power-state control block
// Assumes: 50 MHz system clock, APB register access, serial link sampled by system clock
// Notes:   offsets are byte addresses of 32-bit aligned words
package adc_pwr_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFS     = 8'h00;
    localparam logic [7:0] STATUS_OFFS   = 8'h04;
    localparam logic [7:0] RESULT_OFFS   = 8'h08;
    localparam logic [7:0] IRQ_STAT_OFFS = 8'h0C;
    localparam logic [7:0] IRQ_EN_OFFS   = 8'h10;
    localparam logic [7:0] IRQ_CLR_OFFS  = 8'h14;
    localparam logic [7:0] SAMPLE_OFFS   = 8'h18;

    // ----------------------------------------------------------------
    // control byte fields, msb first; start bit at 7
    // ----------------------------------------------------------------
    localparam int PD_SEL_POS  = 1;
    localparam int CLK_SEL_POS = 0;

    // status / interrupt bits
    localparam int EV_CONV_DONE = 0;
    localparam int EV_WAKE      = 1;
    localparam int EV_ABORT     = 2;
    localparam int EV_SLEEP     = 3;
    localparam int EV_W         = 4;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ         = 50_000_000;
    localparam int CONV_TIME_NS   = 25_000;
    localparam int CONV_CYCLES    = (CONV_TIME_NS * (CLK_HZ / 1_000_000)) / 1_000;
    localparam int WAKE_TIME_NS   = 20_000;
    localparam int WAKE_CYCLES    = (WAKE_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1_000;
    localparam int CODE_STEP_UV   = 16_000;
    localparam int REF_UV         = 4_096_000;
    localparam int CODE_COUNT     = 256;

    // reset values
    localparam logic [7:0]      SAMPLE_RESET  = 8'h00;
    localparam logic [EV_W-1:0] IRQ_EN_RESET  = 4'h0;

    typedef enum logic [2:0] {
        PWR_OFF,
        PWR_IDLE,
        PWR_CONV,
        PWR_SLEEP
    } pwr_state_t;

    typedef enum logic [1:0] {
        REF_OFF,
        REF_ON
    } ref_state_t;

endpackage

//--- pkg/link_if.sv
`timescale 1ns/1ns
// Purpose: carrier of synchronised serial link events between the front end and the core
// Assumes: all signals on the system clock
// Notes:   pulses are one system-clock cycle wide
interface link_if;
    logic       cs_low;
    logic       rise;
    logic       fall;
    logic       din;
    logic       byte_done;
    logic [7:0] ctrl_byte;
    logic       frame_start;
    logic       load;
    logic [7:0] load_data;

    modport front (
        output cs_low, rise, fall, din, byte_done, ctrl_byte, frame_start,
        input  load, load_data
    );
    modport core (
        input  cs_low, rise, fall, din, byte_done, ctrl_byte, frame_start,
        output load, load_data
    );
endinterface

//--- core/link_front.sv
`timescale 1ns/1ns
// Purpose: synchronise the serial pins, find clock edges, frame control bytes, shift out data
// Assumes: serial clock well below a quarter of the system clock
// Notes:   data out changes on the serial clock falling edge, msb first
module link_front
    import adc_pwr_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic srst_in,
    input  wire logic cs_n_in,
    input  wire logic sclk_in,
    input  wire logic din_in,
    output logic      dout_out,
    link_if.front     lk
);

    typedef struct packed {
        logic [1:0] cs_s;
        logic [1:0] ck_s;
        logic [1:0] di_s;
        logic       ck_d;
        logic       framing;
        logic [2:0] cnt;
        logic [7:0] sh_in;
        logic [7:0] sh_out;
        logic       dout;
        logic       rise;
        logic       fall;
        logic       din;
        logic       done;
        logic [7:0] ctrl;
        logic       cs_d;
        logic       fstart;
    } front_state_t;

    front_state_t s_reg;
    front_state_t s_next;

    always_comb begin
        s_next        = s_reg;
        s_next.cs_s   = {s_reg.cs_s[0], cs_n_in};
        s_next.ck_s   = {s_reg.ck_s[0], sclk_in};
        s_next.di_s   = {s_reg.di_s[0], din_in};
        s_next.ck_d   = s_reg.ck_s[1];
        s_next.cs_d   = s_reg.cs_s[1];
        s_next.rise   = !s_reg.cs_s[1] && s_reg.ck_s[1] && !s_reg.ck_d;
        s_next.fall   = !s_reg.cs_s[1] && !s_reg.ck_s[1] && s_reg.ck_d;
        s_next.din    = s_reg.di_s[1];
        s_next.done   = 1'b0;
        s_next.fstart = s_reg.cs_d && !s_reg.cs_s[1];
        if (s_reg.cs_s[1]) begin
            // chip select high discards partial bytes
            s_next.framing = 1'b0;
            s_next.cnt     = 3'd0;
        end else if (s_next.rise) begin
            if (!s_reg.framing) begin
                if (s_reg.di_s[1]) begin
                    s_next.framing = 1'b1;
                    s_next.cnt     = 3'd1;
                    s_next.sh_in   = 8'h01;
                end
            end else begin
                s_next.sh_in = {s_reg.sh_in[6:0], s_reg.di_s[1]};
                s_next.cnt   = s_reg.cnt + 3'd1;
                if (s_reg.cnt == 3'd7) begin
                    s_next.framing = 1'b0;
                    s_next.done    = 1'b1;
                    s_next.ctrl    = {s_reg.sh_in[6:0], s_reg.di_s[1]};
                end
            end
        end
        if (lk.load) begin
            s_next.sh_out = lk.load_data;
        end else if (s_next.fall) begin
            s_next.dout   = s_reg.sh_out[7];
            s_next.sh_out = {s_reg.sh_out[6:0], 1'b0};
        end
        if (srst_in) begin
            s_next = '0;
            s_next.cs_s = 2'b11;
            s_next.cs_d = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        s_reg <= s_next;
    end

    assign dout_out       = s_reg.dout;
    assign lk.cs_low      = !s_reg.cs_s[1];
    assign lk.rise        = s_reg.rise;
    assign lk.fall        = s_reg.fall;
    assign lk.din         = s_reg.din;
    assign lk.byte_done   = s_reg.done;
    assign lk.ctrl_byte   = s_reg.ctrl;
    assign lk.frame_start = s_reg.fstart;

    a_frame_start_bit: assert property (@(posedge clk_in) disable iff (srst_in)
        s_reg.done |-> s_reg.ctrl[7])
        else $error("control byte framed without start bit");

endmodule

//--- core/sar_timer.sv
`timescale 1ns/1ns
// Purpose: internal conversion timer with abort
// Assumes: one start pulse per conversion
// Notes:   done is a one-cycle pulse; abort wins over completion
module sar_timer
    import adc_pwr_pkg::*;
#(
    parameter int CYCLES = CONV_CYCLES
) (
    input  wire logic clk_in,
    input  wire logic srst_in,
    input  wire logic start_in,
    input  wire logic abort_in,
    output logic      busy_out,
    output logic      done_out
);

    initial begin
        if (CYCLES < 2 || CYCLES > 65535) begin
            $error("sar_timer: CYCLES out of range");
        end
    end

    typedef struct packed {
        logic [15:0] cnt;
        logic        busy;
        logic        done;
    } timer_state_t;

    timer_state_t s_reg;
    timer_state_t s_next;

    always_comb begin
        s_next      = s_reg;
        s_next.done = 1'b0;
        if (abort_in) begin
            s_next.busy = 1'b0;
            s_next.cnt  = 16'h0000;
        end else if (start_in) begin
            s_next.busy = 1'b1;
            s_next.cnt  = 16'(CYCLES - 1);
        end else if (s_reg.busy) begin
            if (s_reg.cnt == 16'h0000) begin
                s_next.busy = 1'b0;
                s_next.done = 1'b1;
            end else begin
                s_next.cnt = s_reg.cnt - 16'h0001;
            end
        end
        if (srst_in) begin
            s_next = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        s_reg <= s_next;
    end

    assign busy_out = s_reg.busy;
    assign done_out = s_reg.done;

    a_abort_no_done: assert property (@(posedge clk_in) disable iff (srst_in)
        abort_in |=> !done_out)
        else $error("conversion completed despite abort");

endmodule

//--- core/adc_power_mode_control.sv
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ns
// Purpose: power-state control of a serial 8-bit converter, with apb status and interrupts
// Assumes: shutdown pin reported as two synchronised indications, low and floating
// Notes:   the analog result comes from the SAMPLE register as a stand-in code
module adc_power_mode_control
    import adc_pwr_pkg::*;
#(
    parameter int CONV_CYC = CONV_CYCLES,
    parameter int WAKE_CYC = WAKE_CYCLES
) (
    input  wire logic        CLOCK_IN,
    input  wire logic        SRST_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    input  wire logic        CS_N_IN,
    input  wire logic        SCLK_IN,
    input  wire logic        DIN_IN,
    input  wire logic        HARD_SHUTDOWN_N_LOW_IN,
    input  wire logic        HARD_SHUTDOWN_N_FLOAT_IN,
    output logic             DOUT_OUT,
    output logic             DOUT_OE_OUT,
    output logic             STRB_OUT,
    output logic             STRB_OE_OUT,
    output logic             REF_EN_OUT,
    output logic             IRQ_OUT
);

    initial begin
        if (CONV_CYC < 2 || WAKE_CYC < 1) begin
            $error("adc_power_mode_control: cycle counts out of range");
        end
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0]      shl_s;
        logic [1:0]      shf_s;
        pwr_state_t      st;
        ref_state_t      refst;
        logic            int_clk;
        logic            pd_sel;
        logic            have_result;
        logic [7:0]      result;
        logic [7:0]      sample;
        logic [EV_W-1:0] irq_stat;
        logic [EV_W-1:0] irq_en;
        logic            strb;
        logic            strb_oe;
        logic            dout_oe;
        logic            ref_en;
        logic            irq;
        logic [31:0]     prdata;
        logic            pready;
        logic            pslverr;
        logic            load;
        logic [7:0]      load_data;
        logic            dout;
    } top_state_t;

    top_state_t s_reg;
    top_state_t s_next;

    link_if lk ();

    logic conv_start;
    logic conv_abort;
    logic conv_busy;
    logic conv_done;
    logic dout_w;

    link_front u_front (
        .clk_in  (CLOCK_IN),
        .srst_in (SRST_IN),
        .cs_n_in (CS_N_IN),
        .sclk_in (SCLK_IN),
        .din_in  (DIN_IN),
        .dout_out(dout_w),
        .lk      (lk)
    );

    sar_timer #(.CYCLES(CONV_CYC)) u_timer (
        .clk_in  (CLOCK_IN),
        .srst_in (SRST_IN),
        .start_in(conv_start),
        .abort_in(conv_abort),
        .busy_out(conv_busy),
        .done_out(conv_done)
    );

    // shutdown pin, two synchronised indications
    logic hard_shutdown_n_low;
    logic hard_shutdown_n_float;
    assign hard_shutdown_n_low   = s_reg.shl_s[1];
    assign hard_shutdown_n_float = s_reg.shf_s[1] && !s_reg.shl_s[1];

    // ----------------------------------------------------------------
    // conversion control
    // ----------------------------------------------------------------
    logic       apb_acc;
    logic       apb_wr;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] clr;

    // pready is registered: one wait state, the answer stands one cycle
    assign apb_acc    = PSEL_IN && PENABLE_IN && !s_reg.pready;
    // writes land at the edge that sees pready high, not before
    assign apb_wr     = PSEL_IN && PENABLE_IN && PWRITE_IN && s_reg.pready;
    assign conv_start = lk.byte_done && !hard_shutdown_n_low;
    // a new byte also restarts a running conversion
    assign conv_abort = hard_shutdown_n_low && conv_busy;

    always_comb begin
        s_next           = s_reg;
        s_next.shl_s     = {s_reg.shl_s[0], HARD_SHUTDOWN_N_LOW_IN};
        s_next.shf_s     = {s_reg.shf_s[0], HARD_SHUTDOWN_N_FLOAT_IN};
        s_next.load      = 1'b0;
        s_next.pready    = 1'b0;
        s_next.pslverr   = 1'b0;
        ev               = '0;
        clr              = '0;

        // mode and reference from the pin
        // reference follows the pin only; it is off in hard shutdown
        s_next.refst  = hard_shutdown_n_float ? REF_ON : REF_OFF;
        s_next.ref_en = s_next.refst == REF_ON;

        case (s_reg.st)
            PWR_OFF: begin
                if (!hard_shutdown_n_low) begin
                    s_next.st      = PWR_IDLE;
                    s_next.int_clk = 1'b1;
                    s_next.strb    = 1'b1;
                end
            end
            PWR_IDLE, PWR_SLEEP: begin
                if (lk.byte_done) begin
                    if (s_reg.st == PWR_SLEEP) begin
                        ev[EV_WAKE] = 1'b1;
                    end
                    s_next.pd_sel   = lk.ctrl_byte[PD_SEL_POS];
                    s_next.int_clk  = lk.ctrl_byte[CLK_SEL_POS];
                    s_next.st       = PWR_CONV;
                    s_next.strb     = !lk.ctrl_byte[CLK_SEL_POS];
                end
            end
            PWR_CONV: begin
                if (lk.byte_done) begin
                    s_next.pd_sel  = lk.ctrl_byte[PD_SEL_POS];
                    s_next.int_clk = lk.ctrl_byte[CLK_SEL_POS];
                    s_next.strb    = !lk.ctrl_byte[CLK_SEL_POS];
                end else if (conv_done) begin
                    s_next.result      = s_reg.sample;
                    s_next.have_result = 1'b1;
                    s_next.load        = 1'b1;
                    s_next.load_data   = s_reg.sample;
                    s_next.strb        = 1'b1;
                    ev[EV_CONV_DONE]   = 1'b1;
                    if (s_reg.pd_sel) begin
                        s_next.st = PWR_IDLE;
                    end else begin
                        s_next.st   = PWR_SLEEP;
                        ev[EV_SLEEP] = 1'b1;
                    end
                end
            end
            default: begin
                s_next.st = PWR_OFF;
            end
        endcase

        // shutdown low takes precedence over every state
        if (hard_shutdown_n_low) begin
            if (s_reg.st == PWR_CONV) begin
                ev[EV_ABORT] = 1'b1;
            end
            s_next.st   = PWR_OFF;
            s_next.strb = 1'b0;
        end

        // interface outputs; internal mode keeps the strobe driven outside PWR_OFF
        s_next.dout_oe = lk.cs_low && s_next.st != PWR_OFF;
        s_next.strb_oe = s_next.st != PWR_OFF && (s_next.int_clk || lk.cs_low);
        // without a result the shifter stays loaded with zeros
        if (lk.frame_start && !s_reg.have_result) begin
            s_next.load      = 1'b1;
            s_next.load_data = 8'h00;
        end

        // ----------------------------------------------------------------
        // apb slave
        // ----------------------------------------------------------------
        if (apb_acc) begin
            s_next.pready = 1'b1;
            s_next.prdata = 32'h0000_0000;
            case (PADDR_IN)
                CTRL_OFFS: begin
                    s_next.prdata = {30'h0000_0000, s_reg.pd_sel, s_reg.int_clk};
                end
                STATUS_OFFS: begin
                    s_next.prdata = {26'h0000_000, s_reg.ref_en, hard_shutdown_n_low,
                                     s_reg.have_result, conv_busy, s_reg.st[1:0]};
                end
                RESULT_OFFS: begin
                    s_next.prdata = {24'h00_0000, s_reg.result};
                end
                IRQ_STAT_OFFS: begin
                    s_next.prdata = {28'h000_0000, s_reg.irq_stat};
                end
                IRQ_EN_OFFS: begin
                    s_next.prdata = {28'h000_0000, s_reg.irq_en};
                end
                IRQ_CLR_OFFS: begin
                    // write-only, reads as zero
                end
                SAMPLE_OFFS: begin
                    s_next.prdata = {24'h00_0000, s_reg.sample};
                end
                default: begin
                    s_next.pslverr = 1'b1;
                end
            endcase
        end

        // ----------------------------------------------------------------
        // register writes
        // ----------------------------------------------------------------
        if (apb_wr) begin
            case (PADDR_IN)
                IRQ_EN_OFFS: begin
                    s_next.irq_en = PWDATA_IN[EV_W-1:0];
                end
                IRQ_CLR_OFFS: begin
                    clr = PWDATA_IN[EV_W-1:0];
                end
                SAMPLE_OFFS: begin
                    s_next.sample = PWDATA_IN[7:0];
                end
                default: begin
                    clr = '0;
                end
            endcase
        end

        // set wins over clear
        s_next.irq_stat = (s_reg.irq_stat & ~clr) | ev;
        s_next.irq      = |(s_next.irq_stat & s_next.irq_en);
        // dout re-registered so the pin leaves a flop of this module
        s_next.dout     = dout_w;

        if (SRST_IN) begin
            s_next        = '0;
            s_next.st     = PWR_OFF;
            s_next.refst  = REF_OFF;
            s_next.sample = SAMPLE_RESET;
            s_next.irq_en = IRQ_EN_RESET;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        s_reg <= s_next;
    end

    assign lk.load      = s_reg.load;
    assign lk.load_data = s_reg.load_data;

    assign PRDATA_OUT  = s_reg.prdata;
    assign PREADY_OUT  = s_reg.pready;
    assign PSLVERR_OUT = s_reg.pslverr;
    assign DOUT_OUT    = s_reg.dout;
    assign DOUT_OE_OUT = s_reg.dout_oe;
    assign STRB_OUT    = s_reg.strb;
    assign STRB_OE_OUT = s_reg.strb_oe;
    assign REF_EN_OUT  = s_reg.ref_en;
    assign IRQ_OUT     = s_reg.irq;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_powerup_strobe: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        (s_reg.st == PWR_OFF && !hard_shutdown_n_low) |=> (s_reg.strb && s_reg.int_clk))
        else $error("power-up did not raise strobe in internal mode");
    a_hard_shutdown_n_override: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        hard_shutdown_n_low |=> (s_reg.st == PWR_OFF && !conv_busy))
        else $error("shutdown low did not force power-off");
    a_strobe_low_conv: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        (s_reg.st == PWR_CONV && s_reg.int_clk && !$past(lk.byte_done)) |-> !s_reg.strb)
        else $error("strobe high during internal conversion");
    a_sleep_after: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        (conv_done && s_reg.st == PWR_CONV && !lk.byte_done && !hard_shutdown_n_low)
        |=> (s_reg.st == ($past(s_reg.pd_sel) ? PWR_IDLE : PWR_SLEEP)))
        else $error("wrong power state after conversion");
    a_ref_decode: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        ##1 (REF_EN_OUT == $past(hard_shutdown_n_float)))
        else $error("reference enable mismatch");
    a_zero_before: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        !s_reg.have_result |-> (s_reg.result == 8'h00))
        else $error("result present before first conversion");
    a_wake_start: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        (s_reg.st == PWR_SLEEP && lk.byte_done && !hard_shutdown_n_low) |=> s_reg.st == PWR_CONV)
        else $error("no wake on start bit");
    a_irq_level: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        (s_reg.irq_stat & s_reg.irq_en) != 0 |-> ##[0:1] IRQ_OUT)
        else $error("interrupt not raised");
    a_wake_event: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        (s_reg.st == PWR_SLEEP && lk.byte_done && !hard_shutdown_n_low) |=> s_reg.irq_stat[EV_WAKE])
        else $error("wake event not recorded");
    a_abort_event: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        (s_reg.st == PWR_CONV && hard_shutdown_n_low) |=> s_reg.irq_stat[EV_ABORT])
        else $error("abort event not recorded");
    a_sleep_readout: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        (s_reg.st == PWR_SLEEP && lk.cs_low && !hard_shutdown_n_low) |=> s_reg.dout_oe)
        else $error("serial output not driven in power-down");
    a_sleep_stays: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
        (s_reg.st == PWR_SLEEP && !lk.byte_done && !hard_shutdown_n_low) |=> s_reg.st == PWR_SLEEP)
        else $error("left power-down without start bit");

endmodule

//--- verif/serial_master.sv
// Purpose: serial master model driving select, serial clock and data in
// Assumes: 160 ns serial clock period, own timing, unrelated to the system clock
// Notes:   data out is taken just before each falling edge, a full period after the falling edge that changed it
`timescale 1ns/1ns
module serial_master #(
    parameter int WAKE_NS = 20_000
) (
    input  wire logic dout_in,
    output logic      cs_n_out,
    output logic      sclk_out,
    output logic      din_out
);
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        din_out  = 1'b0;
    end

    // ----------------------------------------------------------------
    // host duties
    // ----------------------------------------------------------------
    task automatic wait_wake();
        #(WAKE_NS);
    endtask

    // serial clock stands low outside frames; sends nb bits from tx msb down
    task automatic xfer(input logic [15:0] tx, input int nb, output logic [15:0] rx);
        rx = 16'h0000;
        #3 cs_n_out = 1'b0;
        for (int i = 15; i > 15 - nb; i--) begin
            din_out = tx[i];
            #80 sclk_out = 1'b1;
            #80 rx = {rx[14:0], dout_in};
            sclk_out = 1'b0;
        end
        #80 cs_n_out = 1'b1;
        din_out = ~din_out;
    endtask
endmodule

//--- verif/adc_power_mode_control_bench.sv
// Purpose: self-checking bench for the converter power-state control
// Assumes: short conversion count, serial master model on the link
// Notes:   apb reads and writes go through one shared task
`timescale 1ns/1ns
module adc_power_mode_control_bench;
    import adc_pwr_pkg::*;
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
$display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
    localparam int CC = 20;
    logic        clk, srst, psel, pen, pwr, slverr, e, cs_n, sclk, din, s_low, s_flt;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, d;
    logic        pready, dout, strb, ref_en, irq, dout_oe, strb_oe;
    logic [15:0] rx;
    int          bad_count, tests_run;

    adc_power_mode_control #(.CONV_CYC(CC)) uut (
        .CLOCK_IN(clk), .SRST_IN(srst), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(slverr), .CS_N_IN(cs_n), .SCLK_IN(sclk),
        .DIN_IN(din), .HARD_SHUTDOWN_N_LOW_IN(s_low), .HARD_SHUTDOWN_N_FLOAT_IN(s_flt), .DOUT_OUT(dout),
        .DOUT_OE_OUT(dout_oe), .STRB_OUT(strb), .STRB_OE_OUT(strb_oe), .REF_EN_OUT(ref_en),
        .IRQ_OUT(irq)
    );
    serial_master m (.dout_in(dout), .cs_n_out(cs_n), .sclk_out(sclk), .din_out(din));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        d = prdata;
        e = slverr;
        psel <= 1'b0;
        pen  <= 1'b0;
        if (n >= 50) begin
            bad_count++;
            tally_and_finish();
        end
    endtask

    // control byte, then bounded wait for the strobe to come back high
    task automatic conv(input logic [7:0] c);
        int n;
        n = 0;
        m.xfer({c, 8'h00}, 8, rx);
        `CHK("strobe_low", 1'b0, strb)
        while (strb !== 1'b1 && n < 5 * CC) begin
            @(posedge clk);
            n++;
        end
        if (strb !== 1'b1) begin
            bad_count++;
            tally_and_finish();
        end
        repeat (4) @(posedge clk);
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        srst = 1'b1;
        psel = 1'b0;
        pen = 1'b0;
        pwr = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        s_low = 1'b0;
        s_flt = 1'b0;
        bad_count = 0;
        tests_run = 0;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        repeat (6) @(posedge clk);
        `CHK("strobe", 1'b1, strb)
        `CHK("ref_en", 1'b0, ref_en)
        `CHK("strb_oe", 1'b1, strb_oe)
        apb(1'b0, CTRL_OFFS, 32'h0000_0000);
        `CHK("clk_mode", 1'b1, d[CLK_SEL_POS])
        m.xfer(16'h0000, 16, rx);
        `CHK("dout_zero", 16'h0000, rx)
        $display("test power_up done");
        m.wait_wake();
        apb(1'b1, IRQ_EN_OFFS, 32'h0000_0001);
        apb(1'b1, SAMPLE_OFFS, 32'h0000_00A5);
        conv(8'h83);
        `CHK("irq", 1'b1, irq)
        apb(1'b0, RESULT_OFFS, 32'h0000_0000);
        `CHK("result", 32'h0000_00A5, d)
        m.xfer(16'h0000, 16, rx);
        `CHK("dout_code", 8'hA5, rx[14:7])
        apb(1'b1, IRQ_CLR_OFFS, 32'h0000_000F);
        apb(1'b0, 8'h1C, 32'h0000_0000);
        `CHK("slverr", 1'b1, e)
        `CHK("irq_clr", 1'b0, irq)
        $display("test convert done");
        apb(1'b1, SAMPLE_OFFS, 32'h0000_003C);
        conv(8'h81);
        apb(1'b0, STATUS_OFFS, 32'h0000_0000);
        `CHK("sleep", 2'(PWR_SLEEP), d[1:0])
        apb(1'b0, IRQ_STAT_OFFS, 32'h0000_0000);
        `CHK("sleep_ev", 1'b1, d[EV_SLEEP])
        fork
            m.xfer(16'h0000, 16, rx);
            begin
                repeat (20) @(posedge clk);
                `CHK("sleep_oe", 1'b1, dout_oe)
            end
        join
        `CHK("sleep_read", 8'h3C, rx[14:7])
        conv(8'h83);
        apb(1'b0, IRQ_STAT_OFFS, 32'h0000_0000);
        `CHK("wake_ev", 1'b1, d[EV_WAKE])
        apb(1'b0, STATUS_OFFS, 32'h0000_0000);
        `CHK("awake", 2'(PWR_IDLE), d[1:0])
        m.xfer({8'h82, 8'h00}, 8, rx);
        repeat (2 * CC) @(posedge clk);
        apb(1'b0, CTRL_OFFS, 32'h0000_0000);
        `CHK("ext_mode", 2'b10, d[1:0])
        $display("test power_down done");
        apb(1'b1, IRQ_CLR_OFFS, 32'h0000_000F);
        m.xfer({8'h83, 8'h00}, 8, rx);
        @(posedge clk);
        s_low <= 1'b1;
        repeat (2 * CC) @(posedge clk);
        `CHK("abort_strb", 1'b0, strb)
        apb(1'b0, IRQ_STAT_OFFS, 32'h0000_0000);
        `CHK("abort_ev", 2'b01, {d[EV_CONV_DONE], d[EV_ABORT]})
        apb(1'b0, STATUS_OFFS, 32'h0000_0000);
        `CHK("off", 2'(PWR_OFF), d[1:0])
        `CHK("off_oe", 2'b00, {strb_oe, dout_oe})
        @(posedge clk);
        s_low <= 1'b0;
        s_flt <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK("ref_float", 1'b1, ref_en)
        $display("test shutdown done");
        tally_and_finish();
    end
endmodule
